// *** hw/sbp_pkg.sv ***
// Constants for the eight-bit shared I/O port.
package sbp_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [19:0] SBP_DIR_ADDR = 20'hEE00A;
  localparam logic [19:0] SBP_DATA_ADDR = 20'hFFFDA;
  localparam logic [19:0] SBP_CFG_ADDR = 20'hFFFE0;
  localparam logic [7:0] SBP_DIR_RST = 8'h00;
  localparam logic [7:0] SBP_DATA_RST = 8'h00;
  localparam logic [7:0] SBP_CFG_RST = 8'h00;
  localparam logic [31:0] SBP_DIR_READ = 32'h000000FF;
  localparam int SBP_TOP_PIN = 7;
  localparam logic [2:0] SBP_MODE_LAST_EXT = 3'h5;

endpackage

// *** hw/sbp_port.sv ***
// Eight-bit shared I/O port with APB register access.
`timescale 1ns/1ps
module sbp_port (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic HW_STBY_I,
  input wire logic SW_STBY_I,
  input wire logic [2:0] MODE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [7:0] PAT_OUT_I,
  input wire logic [7:0] PAT_EN_I,
  input wire logic [7:0] TMR_OUT_I,
  input wire logic [7:0] TMR_OE_I,
  input wire logic [7:0] CS_OUT_I,
  input wire logic [7:0] CS_EN_I,
  input wire logic [7:0] PIN_IN_I,
  output logic [7:0] TMR_IN_O,
  output logic [7:0] PIN_OUT_O,
  output logic [7:0] PIN_OE_O
);
  import sbp_pkg::*;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] dir_q, dir_d;
  logic [7:0] data_q, data_d;
  logic [7:0] cfg_q, cfg_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] port_read;
  logic wr_en, rd_en, hit_dir, hit_data, hit_cfg, err;
  logic ext_mode;

  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0];
  assign rd_en = PSEL_I && !PENABLE_I && !PWRITE_I;
  // Register offsets are word indices; the byte address is four times the index.
  assign hit_dir = PADDR_I == {10'h000, SBP_DIR_ADDR, 2'b00};
  assign hit_data = PADDR_I == {10'h000, SBP_DATA_ADDR, 2'b00};
  assign hit_cfg = PADDR_I == {10'h000, SBP_CFG_ADDR, 2'b00};
  assign err = !(hit_dir || hit_data || hit_cfg);
  assign ext_mode = MODE_I <= SBP_MODE_LAST_EXT;

  always_comb begin
    dir_d = dir_q;
    data_d = data_q;
    cfg_d = cfg_q;
    rdata_d = rdata_q;
    if (SRST_I || HW_STBY_I) begin
      dir_d = SBP_DIR_RST;
      data_d = SBP_DATA_RST;
      cfg_d = SBP_CFG_RST;
      rdata_d = 32'h00000000;
    end else begin
      if (wr_en && hit_dir) begin
        dir_d = PWDATA_I[7:0];
      end
      if (wr_en && hit_data) begin
        data_d = PWDATA_I[7:0];
      end
      if (wr_en && hit_cfg) begin
        cfg_d = PWDATA_I[7:0];
      end
      if (rd_en) begin
        if (hit_dir) begin
          rdata_d = SBP_DIR_READ;
        end else if (hit_data) begin
          rdata_d = {24'h000000, port_read};
        end else if (hit_cfg) begin
          rdata_d = {24'h000000, cfg_q};
        end else begin
          rdata_d = 32'h00000000;
        end
      end
    end
  end

  // Software standby changes nothing here, so settings and drive persist.
  always_ff @(posedge CLK_I) begin
    dir_q <= dir_d;
    data_q <= data_d;
    cfg_q <= cfg_d;
    rdata_q <= rdata_d;
  end

  assign PRDATA_O = rdata_q;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && err;

  // ----------------------------------------
  // Pin multiplexing
  // ----------------------------------------
  // Config bits enable pattern, timer and chip-select claims per pin.
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      logic pat_sel, cs_sel, tmr_sel;
      assign port_read[g] = dir_q[g] ? data_q[g] : PIN_IN_I[g];
      assign pat_sel = PAT_EN_I[g] && dir_q[g] && cfg_q[0];
      assign cs_sel = CS_EN_I[g] && ext_mode && cfg_q[1];
      assign tmr_sel = TMR_OE_I[g] && cfg_q[2];
      always_comb begin
        if (SRST_I || HW_STBY_I) begin
          PIN_OUT_O[g] = 1'b0;
          PIN_OE_O[g] = 1'b0;
        end else if (cs_sel) begin
          PIN_OUT_O[g] = CS_OUT_I[g];
          PIN_OE_O[g] = 1'b1;
        end else if (tmr_sel) begin
          PIN_OUT_O[g] = TMR_OUT_I[g];
          PIN_OE_O[g] = 1'b1;
        end else if (pat_sel) begin
          PIN_OUT_O[g] = PAT_OUT_I[g];
          PIN_OE_O[g] = 1'b1;
        end else begin
          PIN_OUT_O[g] = data_q[g];
          PIN_OE_O[g] = dir_q[g];
        end
      end
    end
  endgenerate

  assign TMR_IN_O = PIN_IN_I;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_dir_reads_ones: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (rd_en && hit_dir && !HW_STBY_I) |=> PRDATA_O == SBP_DIR_READ)
    else $error("Direction read did not return all ones.");
  a_gpio_drive: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (!HW_STBY_I && !CS_EN_I[0] && !TMR_OE_I[0] && !PAT_EN_I[0] && dir_q[0])
    |-> PIN_OE_O[0] && PIN_OUT_O[0] == data_q[0])
    else $error("Output pin does not drive data bit.");
  a_input_float: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (!HW_STBY_I && !CS_EN_I[1] && !TMR_OE_I[1] && !dir_q[1]) |-> !PIN_OE_O[1])
    else $error("Input pin is driven.");
  a_stby_clear: assert property (@(posedge CLK_I)
    HW_STBY_I |=> dir_q == SBP_DIR_RST && data_q == SBP_DATA_RST)
    else $error("Hardware standby did not clear registers.");
  a_read_mix: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (rd_en && hit_data && !HW_STBY_I)
    |=> PRDATA_O[7:0] == (($past(dir_q) & $past(data_q)) | (~$past(dir_q) & $past(PIN_IN_I))))
    else $error("Port read mixes wrong sources.");
  a_swstby_keep: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (SW_STBY_I && !HW_STBY_I && !PSEL_I) |=> $stable(dir_q) && $stable(data_q))
    else $error("Software standby lost settings.");
  a_write_data: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (wr_en && hit_data && !HW_STBY_I) |=> data_q == $past(PWDATA_I[7:0]))
    else $error("Data write not stored.");
  a_pat_top: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (!HW_STBY_I && !CS_EN_I[7] && !TMR_OE_I[7] && cfg_q[0] && PAT_EN_I[7] && dir_q[7])
    |-> PIN_OE_O[7] && PIN_OUT_O[7] == PAT_OUT_I[7])
    else $error("Top pin pattern output wrong.");

endmodule

// *** dv/sbp_board.sv ***
// Board model for the eight port pins.
`timescale 1ns/1ps
module sbp_board (
  input wire logic [7:0] pin_out_i,
  input wire logic [7:0] pin_oe_i,
  input wire logic [7:0] ext_lvl_i,
  output logic [7:0] pin_lvl_o
);
  // Driven pins follow the port; released pins take the board level.
  assign pin_lvl_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_lvl_i);
endmodule

// *** dv/tb_top.sv ***
// Self-checking testbench for the shared I/O port.
`timescale 1ns/1ps
module tb_top;
  import sbp_pkg::*;
  logic clk = 0, rst = 1, hs = 0, ss = 0, ps = 0, pe = 0, pwr = 0, rdy, err, er;
  logic [31:0] pa = 0, pw = 0, prd, rd;
  logic [7:0] ext = 0, cs = 0, pin, pout, poe, tin, pen = 0, pat = 0;
  logic [2:0] m = 3'h7;
  int miscompares = 0, samples_checked = 0;
  sbp_port dut (.CLK_I(clk), .SRST_I(rst), .HW_STBY_I(hs), .SW_STBY_I(ss), .MODE_I(m),
    .PADDR_I(pa), .PSEL_I(ps), .PENABLE_I(pe), .PWRITE_I(pwr), .PWDATA_I(pw), .PSTRB_I(4'hF),
    .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err), .PAT_OUT_I(pat), .PAT_EN_I(pen),
    .TMR_OUT_I(8'h00), .TMR_OE_I(8'h00), .CS_OUT_I(cs), .CS_EN_I(cs), .PIN_IN_I(pin),
    .TMR_IN_O(tin), .PIN_OUT_O(pout), .PIN_OE_O(poe));
  sbp_board brd (.pin_out_i(pout), .pin_oe_i(poe), .ext_lvl_i(ext), .pin_lvl_o(pin));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic apb(input logic w, input logic [19:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    pa <= {10'h000, a, 2'b00};
    pwr <= w;
    pw <= {24'h000000, d};
    ps <= 1'b1;
    @(posedge clk);
    pe <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1 && ++n < 20);
    rd = prd;
    er = err;
    ps <= 1'b0;
    pe <= 1'b0;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    ext <= 8'hA5;
    settle();
    chk("oe", 8'h00, poe);
    apb(1'b0, SBP_DATA_ADDR, 8'h00);
    chk("data", 32'hA5, rd);
    apb(1'b0, SBP_DIR_ADDR, 8'h00);
    chk("dir", SBP_DIR_READ, rd);
    apb(1'b1, SBP_DIR_ADDR, 8'h0F);
    apb(1'b1, SBP_DATA_ADDR, 8'h3C);
    apb(1'b0, SBP_DATA_ADDR, 8'h00);
    chk("mix", 32'hAC, rd);
    settle();
    chk("oe", 8'h0F, poe);
    chk("out", 8'h0C, pout & poe);
    ss <= 1'b1;
    settle();
    chk("oe", 8'h0F, poe);
    apb(1'b0, SBP_DATA_ADDR, 8'h00);
    chk("keep", 32'hAC, rd);
    ss <= 1'b0;
    hs <= 1'b1;
    settle();
    hs <= 1'b0;
    settle();
    chk("oe", 8'h00, poe);
    chk("tmr_in", {24'h000000, pin}, tin);
    apb(1'b1, SBP_CFG_ADDR, 8'h02);
    m <= 3'h5;
    cs <= 8'h80;
    settle();
    chk("cs", 8'h80, poe & pout);
    m <= 3'h7;
    settle();
    chk("cs7", 8'h00, poe);
    cs <= 8'h00;
    apb(1'b1, SBP_DIR_ADDR, 8'hFF);
    apb(1'b0, SBP_DATA_ADDR, 8'h00);
    chk("clr", 32'h00, rd);
    apb(1'b1, SBP_CFG_ADDR, 8'h01);
    pen <= 8'h80;
    pat <= 8'h80;
    settle();
    chk("pat", 8'h80, poe & pout & 8'h80);
    pen <= 8'h00;
    apb(1'b1, 20'h00004, 8'h55);
    chk("err", 1'b1, er);
    apb(1'b0, 20'h00004, 8'h00);
    chk("unm", 32'h00, rd);
    print_verdict();
  end
  initial begin
    #20000;
    miscompares++;
    print_verdict();
  end
endmodule
